// ===== hdl/ctdor_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ctdor_params.svh"

// Notes on behaviour
// - fine delay register reads a fixed present flag in its top bit
// - turning the delay on also turns external edge triggering on
// - integration starts the programmed microseconds after a trigger edge, 21-bit count
// - the delay acts only under the external edge trigger scheme
// - any internal signal can be routed to any output by register, except the input pins, which reach outputs one and two only
// - exposure signal routed out, its leading edge delayable up to 1.05 s
// - readout signal shows sensor readout and follows exposure
// - busy while exposing, reading out or transmitting
// - accept-ready shows a new edge trigger is accepted; zero in level mode
// - four output control registers, mode field at bits 11 to 15
// - invert bit flips the routed signal on the pin
// - pin level bit reads pin state; a write sets the level driven in soft level mode
// - pin level read-back is the real pin whatever the mode
// - bit 1 of each output control register shows modulation capability
// - mode codes: off, soft level, exposure, readout, busy, input, modulation, ready
module ctdor_top
(
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    input wire ctdor_pkg::ctdor_bus_req_type BUS_I,
    output logic [31:0] RDATA_O,
    input wire ctdor_pkg::ctdor_cam_status_type CAM_STATUS_I,
    input wire logic TRIG_PIN_I,
    input wire logic [1:0] INPUT_PIN_I,
    input wire logic [3:0] PULSE_MODULATED_OUT_I,
    output logic [3:0] OUT_PIN_O,
    output logic INTEGRATION_START_O,
    output logic EDGE_TRIGGER_ON_O
);
    import ctdor_pkg::*;

    ctdor_state_type state;
    ctdor_state_type next_state;

    // microsecond prescaler step
    function automatic logic [3:0] sub_step(input logic [3:0] sub);
        if (sub == 4'((`CTDOR_US_CYCLES) - 1))
        begin
            sub_step = 4'h0;
        end
        else
        begin
            sub_step = sub + 4'h1;
        end
    endfunction : sub_step

    function automatic logic sub_wrap(input logic [3:0] sub);
        sub_wrap = (sub == 4'((`CTDOR_US_CYCLES) - 1));
    endfunction : sub_wrap

    // index of an output control register, or 3'h4 if none
    function automatic logic [2:0] out_index(input logic [31:0] addr);
        case (addr)
            `CTDOR_OFS_OUT_CTRL_ONE: out_index = 3'h0;
            `CTDOR_OFS_OUT_CTRL_TWO: out_index = 3'h1;
            `CTDOR_OFS_OUT_CTRL_THREE: out_index = 3'h2;
            `CTDOR_OFS_OUT_CTRL_FOUR: out_index = 3'h3;
            default: out_index = 3'h4;
        endcase
    endfunction : out_index

    // routed source for one pin
    function automatic logic route_src(
        input logic [4:0] mode,
        input logic sw_level,
        input logic exp_out,
        input logic readout,
        input logic busy,
        input logic in_pin,
        input logic pulse,
        input logic ready
    );
        case (mode)
            `CTDOR_MODE_SW_LEVEL: route_src = sw_level;
            `CTDOR_MODE_EXPOSURE: route_src = exp_out;
            `CTDOR_MODE_READOUT: route_src = readout;
            `CTDOR_MODE_BUSY: route_src = busy;
            `CTDOR_MODE_INPUT: route_src = in_pin;
            `CTDOR_MODE_PULSE_MOD: route_src = pulse;
            `CTDOR_MODE_ACCEPT_READY: route_src = ready;
            default: route_src = 1'b0;
        endcase
    endfunction : route_src

    logic [2:0] wr_idx;
    logic [2:0] rd_idx;
    logic trig_edge;
    logic [3:0] in_pin;
    logic [31:0] rd_word;
    logic [3:0] cap_mask;

    always_comb
    begin
        next_state = state;
        wr_idx = out_index(BUS_I.addr);
        rd_idx = wr_idx;
        in_pin = {2'b00, state.in_sync2};
        rd_word = 32'h0000_0000;
        cap_mask = `CTDOR_MOD_CAPABLE_MASK;

        // pin synchronisers
        next_state.trig_sync1 = TRIG_PIN_I;
        next_state.trig_sync2 = state.trig_sync1;
        next_state.trig_prev = state.trig_sync2;
        next_state.in_sync1 = INPUT_PIN_I;
        next_state.in_sync2 = state.in_sync1;
        trig_edge = state.trig_sync2 & ~state.trig_prev;

        // register writes
        if (BUS_I.wr)
        begin
            if (wr_idx != 3'h4)
            begin
                next_state.out_mode[wr_idx[1:0]] =
                    BUS_I.wdata[`CTDOR_POS_MODE_HI:`CTDOR_POS_MODE_LO];
                next_state.out_inv[wr_idx[1:0]] = BUS_I.wdata[`CTDOR_POS_INVERT];
                next_state.sw_level[wr_idx[1:0]] = BUS_I.wdata[`CTDOR_POS_PIN_LEVEL];
            end
            else if (BUS_I.addr == `CTDOR_OFS_FINE_TRIG_DELAY)
            begin
                next_state.delay_on = BUS_I.wdata[`CTDOR_POS_DELAY_ON];
                next_state.delay_us = BUS_I.wdata[`CTDOR_POS_DELAY_HI:`CTDOR_POS_DELAY_LO];
                if (BUS_I.wdata[`CTDOR_POS_DELAY_ON])
                begin
                    next_state.edge_on = 1'b1;
                    next_state.level_mode = 1'b0;
                end
            end
            else if (BUS_I.addr == `CTDOR_OFS_TRIG_CONTROL)
            begin
                next_state.edge_on = BUS_I.wdata[`CTDOR_POS_EDGE_ON];
                next_state.level_mode = BUS_I.wdata[`CTDOR_POS_LEVEL_MODE];
                if (!BUS_I.wdata[`CTDOR_POS_EDGE_ON])
                begin
                    next_state.delay_on = 1'b0;
                end
            end
            else if (BUS_I.addr == `CTDOR_OFS_EXPOSURE_OUT_DELAY)
            begin
                next_state.exp_delay_us = BUS_I.wdata[`CTDOR_POS_EXP_DELAY_HI:0];
            end
        end

        // register reads, data one cycle later
        if (rd_idx != 3'h4)
        begin
            rd_word[`CTDOR_POS_PRESENT] = 1'b1;
            rd_word[`CTDOR_POS_MOD_CAPABLE] = cap_mask[rd_idx[1:0]];
            rd_word[`CTDOR_POS_INVERT] = state.out_inv[rd_idx[1:0]];
            rd_word[`CTDOR_POS_MODE_HI:`CTDOR_POS_MODE_LO] = state.out_mode[rd_idx[1:0]];
            rd_word[`CTDOR_POS_PIN_LEVEL] = state.pins[rd_idx[1:0]];
        end
        else if (BUS_I.addr == `CTDOR_OFS_FINE_TRIG_DELAY)
        begin
            rd_word[`CTDOR_POS_PRESENT] = 1'b1;
            rd_word[`CTDOR_POS_DELAY_ON] = state.delay_on;
            rd_word[`CTDOR_POS_DELAY_HI:`CTDOR_POS_DELAY_LO] = state.delay_us;
        end
        else if (BUS_I.addr == `CTDOR_OFS_TRIG_CONTROL)
        begin
            rd_word[`CTDOR_POS_EDGE_ON] = state.edge_on;
            rd_word[`CTDOR_POS_LEVEL_MODE] = state.level_mode;
        end
        else if (BUS_I.addr == `CTDOR_OFS_EXPOSURE_OUT_DELAY)
        begin
            rd_word[`CTDOR_POS_EXP_DELAY_HI:0] = state.exp_delay_us;
        end
        // read data returns to zero after one cycle
        next_state.rdata = BUS_I.rd ? rd_word : 32'h0000_0000;

        // trigger to integration start
        next_state.start = 1'b0;
        case (state.trig_state)
            TRIG_IDLE:
            begin
                if (trig_edge && state.edge_on)
                begin
                    if (state.delay_on && (state.delay_us != 21'h000000))
                    begin
                        next_state.trig_state = TRIG_WAIT;
                        next_state.trig_cnt = state.delay_us;
                        next_state.trig_sub = 4'h0;
                    end
                    else
                    begin
                        next_state.start = 1'b1;
                    end
                end
            end
            TRIG_WAIT:
            begin
                // further edges are ignored until the start
                next_state.trig_sub = sub_step(state.trig_sub);
                if (sub_wrap(state.trig_sub))
                begin
                    next_state.trig_cnt = state.trig_cnt - 21'h000001;
                    if (state.trig_cnt == 21'h000001)
                    begin
                        next_state.start = 1'b1;
                        next_state.trig_state = TRIG_IDLE;
                    end
                end
                // leaving the edge scheme also drops a start due now
                if (!state.edge_on)
                begin
                    next_state.start = 1'b0;
                    next_state.trig_state = TRIG_IDLE;
                end
            end
            default:
            begin
                next_state.trig_state = TRIG_IDLE;
            end
        endcase

        // exposure leading edge delay
        // the trailing edge is never delayed
        next_state.exp_prev = CAM_STATUS_I.exposure;
        if (!CAM_STATUS_I.exposure)
        begin
            next_state.exp_out = 1'b0;
            next_state.exp_wait = 1'b0;
        end
        else if (!state.exp_prev)
        begin
            if (state.exp_delay_us == 20'h00000)
            begin
                next_state.exp_out = 1'b1;
            end
            else
            begin
                next_state.exp_wait = 1'b1;
                next_state.exp_cnt = state.exp_delay_us;
                next_state.exp_sub = 4'h0;
            end
        end
        else if (state.exp_wait)
        begin
            next_state.exp_sub = sub_step(state.exp_sub);
            if (sub_wrap(state.exp_sub))
            begin
                next_state.exp_cnt = state.exp_cnt - 20'h00001;
                if (state.exp_cnt == 20'h00001)
                begin
                    next_state.exp_wait = 1'b0;
                    next_state.exp_out = 1'b1;
                end
            end
        end

        // camera status signals
        next_state.readout = CAM_STATUS_I.readout;
        next_state.busy = CAM_STATUS_I.exposure | CAM_STATUS_I.readout
            | CAM_STATUS_I.transmit;
        // accept-ready only while no delayed start is pending
        next_state.ready = state.edge_on & ~state.level_mode & CAM_STATUS_I.accept
            & (state.trig_state == TRIG_IDLE);

        // output routing
        for (int i = 0; i < 4; i++)
        begin
            next_state.pins[i] = route_src(state.out_mode[i], state.sw_level[i],
                state.exp_out, state.readout, state.busy, in_pin[i],
                PULSE_MODULATED_OUT_I[i], state.ready) ^ state.out_inv[i];
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state <= '0;
            state.trig_state <= TRIG_IDLE;
            // outputs one and two default to exposure and busy
            state.out_mode[0] <= `CTDOR_RST_MODE_ONE;
            state.out_mode[1] <= `CTDOR_RST_MODE_TWO;
            state.out_mode[2] <= `CTDOR_RST_MODE_OTHER;
            state.out_mode[3] <= `CTDOR_RST_MODE_OTHER;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign RDATA_O = state.rdata;
    assign OUT_PIN_O = state.pins;
    assign INTEGRATION_START_O = state.start;
    assign EDGE_TRIGGER_ON_O = state.edge_on;

endmodule : ctdor_top
`default_nettype wire

// ===== inc/ctdor_params.svh
`ifndef CTDOR_PARAMS_SVH
`define CTDOR_PARAMS_SVH

// byte addresses
`define CTDOR_OFS_OUT_CTRL_ONE 32'hf1000320
`define CTDOR_OFS_OUT_CTRL_TWO 32'hf1000324
`define CTDOR_OFS_OUT_CTRL_THREE 32'hf1000328
`define CTDOR_OFS_OUT_CTRL_FOUR 32'hf100032c
`define CTDOR_OFS_FINE_TRIG_DELAY 32'hf1000400
`define CTDOR_OFS_TRIG_CONTROL 32'hf1000410
`define CTDOR_OFS_EXPOSURE_OUT_DELAY 32'hf1000414

// field positions as lsb-0 indices of the msb-0 numbered word
`define CTDOR_POS_PRESENT 31
`define CTDOR_POS_MOD_CAPABLE 30
`define CTDOR_POS_INVERT 24
`define CTDOR_POS_MODE_LO 16
`define CTDOR_POS_MODE_HI 20
`define CTDOR_POS_PIN_LEVEL 0
`define CTDOR_POS_DELAY_ON 25
`define CTDOR_POS_DELAY_LO 0
`define CTDOR_POS_DELAY_HI 20
`define CTDOR_POS_EXP_DELAY_HI 19
`define CTDOR_POS_EDGE_ON 0
`define CTDOR_POS_LEVEL_MODE 1

// output mode codes
`define CTDOR_MODE_OFF 5'h00
`define CTDOR_MODE_SW_LEVEL 5'h01
`define CTDOR_MODE_EXPOSURE 5'h02
`define CTDOR_MODE_READOUT 5'h06
`define CTDOR_MODE_BUSY 5'h07
`define CTDOR_MODE_INPUT 5'h08
`define CTDOR_MODE_PULSE_MOD 5'h09
`define CTDOR_MODE_ACCEPT_READY 5'h0a

// reset values
`define CTDOR_RST_MODE_ONE 5'h02
`define CTDOR_RST_MODE_TWO 5'h07
`define CTDOR_RST_MODE_OTHER 5'h00
`define CTDOR_MOD_CAPABLE_MASK 4'hf

// time base
`define CTDOR_CLK_PERIOD_NS 100
`define CTDOR_US_NS 1000
`define CTDOR_US_CYCLES (`CTDOR_US_NS / `CTDOR_CLK_PERIOD_NS)

`endif

// ===== inc/ctdor_pkg.sv
`default_nettype none
package ctdor_pkg;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ctdor_bus_req_type;

    typedef struct packed {
        logic exposure;
        logic readout;
        logic transmit;
        logic accept;
    } ctdor_cam_status_type;

    typedef enum logic [1:0] {
        TRIG_IDLE = 2'b01,
        TRIG_WAIT = 2'b10
    } ctdor_trig_state_type;

    typedef struct packed {
        logic trig_sync1;
        logic trig_sync2;
        logic trig_prev;
        logic [1:0] in_sync1;
        logic [1:0] in_sync2;
        logic [3:0][4:0] out_mode;
        logic [3:0] out_inv;
        logic [3:0] sw_level;
        logic [3:0] pins;
        logic delay_on;
        logic [20:0] delay_us;
        logic edge_on;
        logic level_mode;
        logic [19:0] exp_delay_us;
        ctdor_trig_state_type trig_state;
        logic [3:0] trig_sub;
        logic [20:0] trig_cnt;
        logic start;
        logic exp_prev;
        logic exp_wait;
        logic [3:0] exp_sub;
        logic [19:0] exp_cnt;
        logic exp_out;
        logic readout;
        logic busy;
        logic ready;
        logic [31:0] rdata;
    } ctdor_state_type;

endpackage : ctdor_pkg
`default_nettype wire

// ===== verif/camera_trigger_delay_output_routing_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "ctdor_params.svh"
module camera_trigger_delay_output_routing_test;
    import ctdor_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    ctdor_bus_req_type bus = '0;
    ctdor_cam_status_type st = '0;
    logic fire = 1'b0;
    logic [1:0] in_lvl = 2'h0;
    logic [3:0] pulse = 4'h0;
    logic [31:0] rdata;
    logic [31:0] word;
    logic [3:0] pins;
    logic [3:0] inv;
    logic [3:0] expv;
    logic start, edge_on, trig;
    logic [1:0] in_pin;
    logic [3:0] seen;
    logic [15:0] seed = 16'h94da;
    logic [4:0] modes [9] = '{5'h00, 5'h01, 5'h02, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h03};
    int errors = 0;
    int n_compared = 0;
    int n;
    ctdor_top DUT (.CLK_SYS_I(clk), .RST_B_I(rst_b), .BUS_I(bus), .RDATA_O(rdata),
        .CAM_STATUS_I(st), .TRIG_PIN_I(trig), .INPUT_PIN_I(in_pin),
        .PULSE_MODULATED_OUT_I(pulse), .OUT_PIN_O(pins), .INTEGRATION_START_O(start),
        .EDGE_TRIGGER_ON_O(edge_on));
    ctdor_partner u_far (.clk_i(clk), .fire_i(fire), .in_level_i(in_lvl), .out_pin_i(pins),
        .trig_pin_o(trig), .in_pin_o(in_pin), .seen_o(seen));
    initial
    begin
        forever #50 clk = ~clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [31:0] ow(input logic [4:0] m, input logic iv, input logic lv);
        return {7'h0, iv, 3'h0, m, 15'h0, lv};
    endfunction : ow
    // expected routed source for pin p
    function automatic logic src(input logic [4:0] m, input int p, input logic rdy);
        case (m)
            5'h01: return seed[p];
            5'h02: return st.exposure;
            5'h06: return st.readout;
            5'h07: return st.exposure | st.readout | st.transmit;
            5'h08: return p < 2 ? in_lvl[p] : 1'b0;
            5'h09: return pulse[p];
            5'h0a: return rdy & st.accept;
            default: return 1'b0;
        endcase
    endfunction : src
    task automatic final_report();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
            errors++;
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 word = rdata;
    endtask : rd
    task automatic trigger_count(input int lim);
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        n = 1;
        while (start !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            #1 n++;
        end
    endtask : trigger_count
    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        for (int p = 0; p < 4; p++)
        begin
            rd(`CTDOR_OFS_OUT_CTRL_ONE + 32'(4 * p));
            chk(word, 32'hc0000000 | ow(p == 0 ? 5'h02 : (p == 1 ? 5'h07 : 5'h00), 0, 0));
        end
        for (int k = 0; k < 12; k++)
        begin
            seed = lfsr(seed);
            @(posedge clk);
            st <= seed[3:0];
            repeat (5) @(posedge clk);
            #1 chk(pins[1:0], {st.exposure | st.readout | st.transmit, st.exposure});
        end
        for (int t = 0; t < 3; t++)
        begin
            wr(`CTDOR_OFS_TRIG_CONTROL, 32'(t == 0 ? 0 : 2 * t - 1));
            foreach (modes[j])
            begin
                seed = lfsr(seed);
                @(posedge clk);
                st <= seed[7:4];
                pulse <= seed[11:8];
                in_lvl <= seed[13:12];
                inv = modes[j] == 5'h01 ? 4'h0 : seed[15:12] ^ seed[3:0];
                for (int p = 0; p < 4; p++)
                    wr(`CTDOR_OFS_OUT_CTRL_ONE + 32'(4 * p), ow(modes[j], inv[p], seed[p]));
                repeat (6) @(posedge clk);
                #1 for (int p = 0; p < 4; p++)
                    expv[p] = src(modes[j], p, t == 1) ^ inv[p];
                chk(seen, expv);
                for (int p = 0; p < 4; p++)
                begin
                    rd(`CTDOR_OFS_OUT_CTRL_ONE + 32'(4 * p));
                    chk(word, 32'hc0000000 | ow(modes[j], inv[p], expv[p]));
                end
            end
        end
        wr(`CTDOR_OFS_OUT_CTRL_ONE, ow(5'h02, 0, 0));
        wr(`CTDOR_OFS_EXPOSURE_OUT_DELAY, 32'h2);
        rd(`CTDOR_OFS_EXPOSURE_OUT_DELAY);
        chk(word, 32'h2);
        @(posedge clk);
        st <= 4'h0;
        repeat (3) @(posedge clk);
        st <= 4'h8;
        repeat (2 * `CTDOR_US_CYCLES + 1) @(posedge clk);
        #1 chk(pins[0], 0);
        @(posedge clk);
        #1 chk(pins[0], 1);
        @(posedge clk);
        st <= 4'h0;
        repeat (2) @(posedge clk);
        #1 chk(pins[0], 0);
        for (int d = 0; d < 4; d += 3)
        begin
            wr(`CTDOR_OFS_FINE_TRIG_DELAY, 32'h02000000 | d);
            rd(`CTDOR_OFS_FINE_TRIG_DELAY);
            chk(word, 32'h82000000 | d);
            chk(32'(edge_on), 1);
            trigger_count(200);
            chk(32'(n >= d * 10 + 2 && n <= d * 10 + 6), 1);
            if (n == 200)
                final_report();
        end
        wr(`CTDOR_OFS_TRIG_CONTROL, 32'h0);
        rd(`CTDOR_OFS_FINE_TRIG_DELAY);
        chk(word, 32'h80000003);
        trigger_count(60);
        chk(32'(n), 60);
        rd(32'hf1000330);
        chk(word, 32'h0);
        final_report();
    end
endmodule : camera_trigger_delay_output_routing_test
`default_nettype wire

// ===== verif/ctdor_partner.sv
`timescale 1ns/100ps
`default_nettype none
module ctdor_partner
(
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic [1:0] in_level_i,
    input wire logic [3:0] out_pin_i,
    output logic trig_pin_o,
    output logic [1:0] in_pin_o,
    output logic [3:0] seen_o
);
    logic [2:0] hold = 3'h0;
    // trigger pulse held five cycles
    always_ff @(posedge clk_i)
    begin
        if (fire_i)
            hold <= 3'h5;
        else if (hold != 3'h0)
            hold <= hold - 3'h1;
    end
    assign trig_pin_o = hold != 3'h0;
    assign in_pin_o = in_level_i;
    // levels seen across the load resistors
    assign seen_o = out_pin_i;
endmodule : ctdor_partner
`default_nettype wire

// ===== verif/ctdor_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "ctdor_params.svh"
module ctdor_checker
(
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    input wire ctdor_pkg::ctdor_bus_req_type BUS_I,
    input wire logic [31:0] RDATA_O,
    input wire logic [3:0] OUT_PIN_O,
    input wire logic INTEGRATION_START_O,
    input wire logic EDGE_TRIGGER_ON_O
);
    import ctdor_pkg::*;
    logic is_out;
    logic is_dly;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_B_I);
    assign is_out = (BUS_I.addr[31:4] == 28'hf100032) && (BUS_I.addr[1:0] == 2'h0);
    assign is_dly = BUS_I.addr == `CTDOR_OFS_FINE_TRIG_DELAY;
    chk_rdata_idle: assert property (!$past(BUS_I.rd) |-> RDATA_O == 32'h0)
        else $error("read data not zero outside a read");
    chk_present_flag: assert property ($past(BUS_I.rd && is_dly) |-> RDATA_O[31])
        else $error("delay present flag missing");
    chk_out_ro_bits: assert property ($past(BUS_I.rd && is_out) |-> RDATA_O[31:30] == 2'h3)
        else $error("output control read-only bits wrong");
    chk_pin_readback: assert property ($past(BUS_I.rd && is_out)
        |-> RDATA_O[0] == $past(OUT_PIN_O[BUS_I.addr[3:2]])) else $error("pin read-back wrong");
    chk_start_pulse: assert property (INTEGRATION_START_O |=> !INTEGRATION_START_O)
        else $error("start longer than one cycle");
    chk_start_edge_only: assert property (INTEGRATION_START_O |-> $past(EDGE_TRIGGER_ON_O))
        else $error("start without edge trigger scheme");
    chk_delay_edge_on: assert property (BUS_I.wr && is_dly && BUS_I.wdata[25]
        |=> EDGE_TRIGGER_ON_O) else $error("delay on did not enable edge trigger");
    chk_sw_level_pin: assert property (BUS_I.wr && is_out && !BUS_I.wdata[24]
        && BUS_I.wdata[20:16] == `CTDOR_MODE_SW_LEVEL
        |-> ##3 OUT_PIN_O[$past(BUS_I.addr[3:2], 3)] == $past(BUS_I.wdata[0], 3))
        else $error("software level not on pin");
    cov_start: cover property (INTEGRATION_START_O);
    cov_pin_high_read: cover property ($past(BUS_I.rd && is_out) && RDATA_O[0]);
    cov_edge_on: cover property ($rose(EDGE_TRIGGER_ON_O));
endmodule : ctdor_checker
bind ctdor_top ctdor_checker u_chk (.CLK_SYS_I, .RST_B_I, .BUS_I, .RDATA_O, .OUT_PIN_O,
    .INTEGRATION_START_O, .EDGE_TRIGGER_ON_O);
`default_nettype wire
